// ### rtl/hfs_defs.svh
// register offsets, field positions, status codes and reset values of the hdlc fifo/status block
//
// Behaviour
// R1 - fifo condition interrupts fire on rising edge
// R2 - packet and message-end events gated by mask
// R3 - packet status follows last popped receive byte
// R4 - packet status codes 000 to 101
// R5 - seven or more ones abort the packet
// R6 - full fifo overruns; three bytes or less short
// R7 - live rx empty, tx full, tx empty flags
// R8 - opening-byte flag when head starts a message
// R9 - tx empty mid-message sends abort, sticky underrun
// R10 - tx free byte count readable
// R11 - rx readable count up to message end
// R12 - top bit says message continues
// R13 - tx port write pushes one byte
// R14 - rx port read pops one byte
// R15 - host sets up controller, enables end/watermark interrupts
// R16 - host pops count, checks status, re-arms
// R17 - each fifo holds 128 bytes
// R18 - event bits latched, cleared by status read
// R19 - packet end on completion or any fault
// R20 - interrupt while any enabled source pending
`ifndef HFS_DEFS_SVH
`define HFS_DEFS_SVH

// ==========================================================================
// register offsets
`define HFS_ADDR_EVENT_INFO 8'h2d
`define HFS_ADDR_PKT_INFO1 8'h2e
`define HFS_ADDR_PKT_INFO2 8'h2f
`define HFS_ADDR_RX_CNT1 8'h9c
`define HFS_ADDR_TX_PORT1 8'h9d
`define HFS_ADDR_RX_PORT1 8'h9e
`define HFS_ADDR_TX_SPACE1 8'h9f
`define HFS_ADDR_RX_CNT2 8'hac
`define HFS_ADDR_TX_PORT2 8'had
`define HFS_ADDR_RX_PORT2 8'hae
`define HFS_ADDR_TX_SPACE2 8'haf
`define HFS_ADDR_STATUS1 8'h20
`define HFS_ADDR_MASK1 8'h21
`define HFS_ADDR_STATUS2 8'h22
`define HFS_ADDR_MASK2 8'h23
`define HFS_ADDR_TX_CTL1 8'h2a
`define HFS_ADDR_TX_CTL2 8'h2b

// ==========================================================================
// fields
`define HFS_TX_CTL_MSG_END_BIT 0
`define HFS_MASK_RESET 8'h00
`define HFS_FIFO_DEPTH 128
`define HFS_CRC_BYTES 2
`define HFS_SHORT_MAX 4'h3
`define HFS_ABORT_ONES 3'h7

// ==========================================================================
// packet status codes
`define HFS_PS_PROGRESS 3'h0
`define HFS_PS_OK 3'h1
`define HFS_PS_CRC_ERR 3'h2
`define HFS_PS_ABORT 3'h3
`define HFS_PS_OVERRUN 3'h4
`define HFS_PS_SHORT 3'h5

`endif

// ### rtl/hfs_pkg.sv
// types shared by the hdlc fifo/status block
`default_nettype none
package hfs_pkg;

  // ========================================================================
  // receive side from the deframer
  typedef struct packed {
    logic byte_valid;
    logic [7:0] data;
    logic msg_end;
    logic crc_ok;
    logic bit_valid;
    logic line_bit;
  } hfs_rx_in_t;

  // ========================================================================
  // transmit side towards the framer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
    logic abort;
  } hfs_tx_out_t;

endpackage : hfs_pkg
`default_nettype wire

// ### rtl/hfs_top.sv
// host fifo, status and interrupt logic for two hdlc controllers
`include "hfs_defs.svh"
`default_nettype none
module hfs_top import hfs_pkg::*; #(
  parameter int DEPTH = `HFS_FIFO_DEPTH,
  parameter int AW = 7,
  parameter int CRC_BYTES = `HFS_CRC_BYTES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // controller side, index 0 is controller 1
  input wire hfs_rx_in_t rx_in [2],
  input wire logic [7:0] rx_high_mark [2],
  input wire logic [7:0] tx_low_mark [2],
  input wire logic tx_req [2],
  input wire logic tx_sent_done [2],
  output hfs_tx_out_t tx_out [2],
  // interrupt
  output logic irq
);

  localparam logic [7:0] DEPTH8 = 8'(DEPTH);

  // ========================================================================
  // helpers
  function automatic logic [7:0] pick(input logic c, input logic [7:0] a1,
                                      input logic [7:0] a2);
    return c ? a2 : a1;
  endfunction : pick

  // bytes from the head up to and including the first terminated entry
  function automatic logic [7:0] readable(input logic [2:0] st [DEPTH],
                                          input logic [AW-1:0] rp,
                                          input logic [7:0] n);
    logic [7:0] k;
    logic done;
    logic [AW-1:0] idx;
    k = 8'h00;
    done = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      idx = rp + AW'(i);
      if (!done && (8'(i) < n)) begin
        k = 8'(i + 1);
        if (st[idx] != `HFS_PS_PROGRESS) begin
          done = 1'b1;
        end
      end
    end
    // a message end beyond 127 bytes is reported as a continuation first;
    // an empty fifo reads as zero with the continuation bit clear
    if ((!done && (k != 8'h00)) || (k > 8'h7f)) begin
      return {1'b1, (k > 8'h7f) ? 7'h7f : k[6:0]}; // [R11] [R12]
    end
    return {1'b0, k[6:0]}; // [R12]
  endfunction : readable

  // ========================================================================
  // state
  logic [7:0] rxd_ff [2][DEPTH];
  logic [2:0] rxs_ff [2][DEPTH];
  logic rxf_ff [2][DEPTH];
  logic [AW-1:0] rx_wp_ff [2];
  logic [AW-1:0] rx_rp_ff [2];
  logic [7:0] rx_cnt_ff [2];
  logic rx_msg_ff [2];
  logic [2:0] msg_len_ff [2];
  logic [2:0] ones_ff [2];
  logic [2:0] ps_ff [2];
  logic [7:0] txd_ff [2][DEPTH];
  logic txe_ff [2][DEPTH];
  logic [AW-1:0] tx_wp_ff [2];
  logic [AW-1:0] tx_rp_ff [2];
  logic [7:0] tx_cnt_ff [2];
  logic tx_msg_ff [2];
  logic udr_ff [2];
  logic [7:0] mask_ff [2];
  logic [3:0] cond_q_ff [2];
  logic [3:0] edge_ff [2];
  logic [2:0] ev_ff [2];
  logic [7:0] rdata_ff;
  logic irq_ff;

  // ========================================================================
  // per-controller decode and events
  logic rx_pop [2];
  logic rx_push [2];
  logic rx_full [2];
  logic ovr [2];
  logic abt [2];
  logic endm [2];
  logic term [2];
  logic [2:0] code [2];
  logic [7:0] rx_left [2];
  logic [3:0] len_now [2];
  logic tx_wr [2];
  logic tx_mark [2];
  logic tx_pop [2];
  logic tx_udr [2];
  logic popped_last [2];
  logic [3:0] cond [2];
  logic [2:0] ev_set [2];
  logic stat_rd [2];
  logic [7:0] rx_avail [2];

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      rx_full[c] = (rx_cnt_ff[c] == DEPTH8);
      rx_pop[c] = reg_rd && (reg_addr == pick(c[0], `HFS_ADDR_RX_PORT1, `HFS_ADDR_RX_PORT2))
                  && (rx_cnt_ff[c] != 8'h00); // [R14]
      rx_push[c] = rx_in[c].byte_valid && !rx_full[c];
      ovr[c] = rx_in[c].byte_valid && rx_full[c] && rx_msg_ff[c]; // [R6]
      abt[c] = rx_in[c].bit_valid && rx_in[c].line_bit
               && (ones_ff[c] == `HFS_ABORT_ONES - 3'h1) && rx_msg_ff[c]; // [R5]
      endm[c] = rx_in[c].msg_end && (rx_msg_ff[c] || rx_push[c]);
      term[c] = ovr[c] || abt[c] || endm[c];
      len_now[c] = (rx_msg_ff[c] ? {1'b0, msg_len_ff[c]} : 4'h0) + {3'h0, rx_push[c]};
      if (ovr[c]) begin
        code[c] = `HFS_PS_OVERRUN; // [R6]
      end else if (abt[c]) begin
        code[c] = `HFS_PS_ABORT; // [R5]
      end else if ((len_now[c] + 4'(CRC_BYTES)) <= `HFS_SHORT_MAX) begin
        code[c] = `HFS_PS_SHORT; // [R6]
      end else if (rx_in[c].crc_ok) begin
        code[c] = `HFS_PS_OK; // [R4]
      end else begin
        code[c] = `HFS_PS_CRC_ERR; // [R4]
      end
      rx_left[c] = rx_cnt_ff[c] - {7'h00, rx_pop[c]};
      tx_wr[c] = reg_wr && (reg_addr == pick(c[0], `HFS_ADDR_TX_PORT1, `HFS_ADDR_TX_PORT2))
                 && (tx_cnt_ff[c] != DEPTH8); // [R13]
      tx_mark[c] = reg_wr && (reg_addr == pick(c[0], `HFS_ADDR_TX_CTL1, `HFS_ADDR_TX_CTL2))
                   && reg_wdata[`HFS_TX_CTL_MSG_END_BIT] && (tx_cnt_ff[c] != 8'h00);
      tx_pop[c] = tx_req[c] && (tx_cnt_ff[c] != 8'h00);
      tx_udr[c] = tx_req[c] && (tx_cnt_ff[c] == 8'h00) && tx_msg_ff[c]; // [R9]
      // a mark landing on the very byte being taken still ends the message
      popped_last[c] = txe_ff[c][tx_rp_ff[c]] || (tx_mark[c] && (tx_cnt_ff[c] == 8'h01));
      cond[c] = {(rx_cnt_ff[c] > rx_high_mark[c]), (rx_cnt_ff[c] != 8'h00),
                 (tx_cnt_ff[c] < tx_low_mark[c]), (tx_cnt_ff[c] != DEPTH8)}; // [R17]
      ev_set[c] = {tx_sent_done[c], term[c], rx_push[c] && !rx_msg_ff[c]}; // [R19]
      stat_rd[c] = reg_rd && (reg_addr == pick(c[0], `HFS_ADDR_STATUS1, `HFS_ADDR_STATUS2));
      rx_avail[c] = readable(rxs_ff[c], rx_rp_ff[c], rx_cnt_ff[c]);
    end
  end

  // ========================================================================
  // receive fifo storage and pointers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int c = 0; c < 2; c++) begin
        rx_wp_ff[c] <= '0;
        rx_rp_ff[c] <= '0;
        rx_cnt_ff[c] <= 8'h00;
        for (int i = 0; i < DEPTH; i++) begin
          rxd_ff[c][i] <= 8'h00;
          rxs_ff[c][i] <= `HFS_PS_PROGRESS;
          rxf_ff[c][i] <= 1'b0;
        end
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (rx_push[c]) begin
          rxd_ff[c][rx_wp_ff[c]] <= rx_in[c].data;
          rxf_ff[c][rx_wp_ff[c]] <= !rx_msg_ff[c];
          rxs_ff[c][rx_wp_ff[c]] <= term[c] ? code[c] : `HFS_PS_PROGRESS;
          rx_wp_ff[c] <= rx_wp_ff[c] + AW'(1);
        end else if (term[c] && (rx_left[c] != 8'h00)) begin
          // newest stored byte is the message's last one
          rxs_ff[c][rx_wp_ff[c] - AW'(1)] <= code[c]; // [R19]
        end
        if (rx_pop[c]) begin
          rx_rp_ff[c] <= rx_rp_ff[c] + AW'(1);
        end
        rx_cnt_ff[c] <= rx_left[c] + {7'h00, rx_push[c]};
      end
    end
  end

  // ========================================================================
  // receive message tracking
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int c = 0; c < 2; c++) begin
        rx_msg_ff[c] <= 1'b0;
        msg_len_ff[c] <= 3'h0;
        ones_ff[c] <= 3'h0;
        ps_ff[c] <= `HFS_PS_PROGRESS;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (term[c]) begin
          rx_msg_ff[c] <= 1'b0;
        end else if (rx_push[c]) begin
          rx_msg_ff[c] <= 1'b1;
        end
        if (rx_push[c]) begin
          msg_len_ff[c] <= (len_now[c] > 4'h7) ? 3'h7 : len_now[c][2:0];
        end
        if (rx_in[c].bit_valid) begin
          if (!rx_in[c].line_bit) begin
            ones_ff[c] <= 3'h0;
          end else if (ones_ff[c] != `HFS_ABORT_ONES) begin
            ones_ff[c] <= ones_ff[c] + 3'h1; // [R5]
          end
        end
        // status is the state of the byte just popped, or the code itself when a message ends with nothing left to read
        if (term[c] && !rx_push[c] && (rx_left[c] == 8'h00)) begin
          ps_ff[c] <= code[c]; // [R3]
        end else if (rx_pop[c]) begin
          ps_ff[c] <= rxs_ff[c][rx_rp_ff[c]]; // [R3]
        end
      end
    end
  end

  // ========================================================================
  // transmit fifo and framer handoff
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int c = 0; c < 2; c++) begin
        tx_wp_ff[c] <= '0;
        tx_rp_ff[c] <= '0;
        tx_cnt_ff[c] <= 8'h00;
        tx_msg_ff[c] <= 1'b0;
        tx_out[c] <= '0;
        for (int i = 0; i < DEPTH; i++) begin
          txd_ff[c][i] <= 8'h00;
          txe_ff[c][i] <= 1'b0;
        end
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (tx_wr[c]) begin
          txd_ff[c][tx_wp_ff[c]] <= reg_wdata; // [R13]
          txe_ff[c][tx_wp_ff[c]] <= 1'b0;
          tx_wp_ff[c] <= tx_wp_ff[c] + AW'(1);
        end else if (tx_mark[c]) begin
          txe_ff[c][tx_wp_ff[c] - AW'(1)] <= 1'b1;
        end
        if (tx_pop[c]) begin
          tx_rp_ff[c] <= tx_rp_ff[c] + AW'(1);
          tx_msg_ff[c] <= !popped_last[c];
        end else if (tx_udr[c]) begin
          tx_msg_ff[c] <= 1'b0;
        end
        tx_cnt_ff[c] <= tx_cnt_ff[c] + {7'h00, tx_wr[c]} - {7'h00, tx_pop[c]};
        tx_out[c].valid <= tx_pop[c];
        tx_out[c].data <= tx_pop[c] ? txd_ff[c][tx_rp_ff[c]] : 8'h00;
        tx_out[c].last <= tx_pop[c] && popped_last[c];
        tx_out[c].abort <= tx_udr[c]; // [R9]
      end
    end
  end

  // ========================================================================
  // masks, edge capture and latched events
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int c = 0; c < 2; c++) begin
        mask_ff[c] <= `HFS_MASK_RESET;
        cond_q_ff[c] <= 4'h0;
        edge_ff[c] <= 4'h0;
        ev_ff[c] <= 3'h0;
        udr_ff[c] <= 1'b0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (reg_wr && (reg_addr == pick(c[0], `HFS_ADDR_MASK1, `HFS_ADDR_MASK2))) begin
          mask_ff[c] <= {1'b0, reg_wdata[6:0]};
        end
        cond_q_ff[c] <= cond[c];
        // only a false-to-true change with the mask open counts; set wins over clear
        edge_ff[c] <= (edge_ff[c] & ~{4{stat_rd[c]}})
                      | (cond[c] & ~cond_q_ff[c] & mask_ff[c][3:0]); // [R1]
        ev_ff[c] <= (ev_ff[c] & ~{3{stat_rd[c]}}) | ev_set[c]; // [R18]
        udr_ff[c] <= (udr_ff[c] && !(reg_rd && (reg_addr == `HFS_ADDR_EVENT_INFO)))
                     || tx_udr[c]; // [R9]
      end
    end
  end

  // ========================================================================
  // interrupt output
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (|(edge_ff[0] & mask_ff[0][3:0])) || (|(edge_ff[1] & mask_ff[1][3:0]))
                || (|(ev_ff[0] & mask_ff[0][6:4]))
                || (|(ev_ff[1] & mask_ff[1][6:4])); // [R1] [R2] [R20]
    end
  end

  assign irq = irq_ff;

  // ========================================================================
  // register read path, data in the cycle after the strobe only
  logic [7:0] rd_val;

  always_comb begin
    rd_val = 8'h00;
    case (reg_addr)
      `HFS_ADDR_EVENT_INFO: begin
        rd_val = {4'h0, udr_ff[1], rxf_ff[1][rx_rp_ff[1]] && (rx_cnt_ff[1] != 8'h00),
                  udr_ff[0], rxf_ff[0][rx_rp_ff[0]] && (rx_cnt_ff[0] != 8'h00)}; // [R8]
      end
      `HFS_ADDR_PKT_INFO1: begin
        rd_val = {2'h0, tx_cnt_ff[0] == 8'h00, tx_cnt_ff[0] == DEPTH8,
                  rx_cnt_ff[0] == 8'h00, ps_ff[0]}; // [R7] [R4]
      end
      `HFS_ADDR_PKT_INFO2: begin
        rd_val = {2'h0, tx_cnt_ff[1] == 8'h00, tx_cnt_ff[1] == DEPTH8,
                  rx_cnt_ff[1] == 8'h00, ps_ff[1]}; // [R7] [R4]
      end
      `HFS_ADDR_RX_CNT1: begin
        rd_val = rx_avail[0]; // [R11]
      end
      `HFS_ADDR_RX_CNT2: begin
        rd_val = rx_avail[1]; // [R11]
      end
      `HFS_ADDR_RX_PORT1: begin
        rd_val = rxd_ff[0][rx_rp_ff[0]]; // [R14]
      end
      `HFS_ADDR_RX_PORT2: begin
        rd_val = rxd_ff[1][rx_rp_ff[1]]; // [R14]
      end
      `HFS_ADDR_TX_SPACE1: begin
        rd_val = DEPTH8 - tx_cnt_ff[0]; // [R10]
      end
      `HFS_ADDR_TX_SPACE2: begin
        rd_val = DEPTH8 - tx_cnt_ff[1]; // [R10]
      end
      `HFS_ADDR_STATUS1: begin
        rd_val = {1'b0, ev_ff[0], cond[0]};
      end
      `HFS_ADDR_STATUS2: begin
        rd_val = {1'b0, ev_ff[1], cond[1]};
      end
      `HFS_ADDR_MASK1: begin
        rd_val = mask_ff[0];
      end
      `HFS_ADDR_MASK2: begin
        rd_val = mask_ff[1];
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd ? rd_val : 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule : hfs_top
`default_nettype wire

// ### verification/hfs_checker.sv
// port-level assertions for the hdlc fifo/status block
`default_nettype none
module hfs_checker import hfs_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // controller side
  input wire logic tx_req [2],
  input wire hfs_tx_out_t tx_out [2],
  input wire logic irq
);
  // ==========
  // assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside the answer cycle");
  space_max_a: assert property (reg_rd && reg_addr == 8'h9f |=> reg_rdata <= 8'h80)
    else $error("tx free count above depth");
  info_pad_a: assert property (reg_rd && reg_addr == 8'h2e |=> reg_rdata[7:6] == 2'b00)
    else $error("packet info top bits set");
  event_pad_a: assert property (reg_rd && reg_addr == 8'h2d |=> reg_rdata[7:4] == 4'h0)
    else $error("event info top bits set");
  mask_pad_a: assert property (reg_rd && reg_addr == 8'h21 |=> !reg_rdata[7])
    else $error("mask bit 7 reads one");
  status_code_a: assert property (reg_rd && reg_addr == 8'h2e |=> reg_rdata[2:0] <= 3'h5)
    else $error("packet status code out of range");
  tx_cause_a: assert property (tx_out[0].valid || tx_out[0].abort |-> $past(tx_req[0]))
    else $error("tx output without request");
  abort_excl_a: assert property (tx_out[1].abort |-> !tx_out[1].valid && $past(tx_req[1]))
    else $error("abort with byte or without request");
  cover property (tx_out[0].abort || tx_out[1].abort);
  cover property ($rose(irq));
  cover property (reg_rd && reg_addr == 8'h9e ##1 reg_rdata != 8'h00);
endmodule : hfs_checker
bind hfs_top hfs_checker i_hfs_checker (.clock(clock), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_req(tx_req),
  .tx_out(tx_out), .irq(irq));
`default_nettype wire

// ### verification/hfs_framer_model.sv
// framer stand-in: asks for transmit bytes and keeps what the block hands over
`default_nettype none
module hfs_framer_model import hfs_pkg::*; (
  // clock
  input wire logic clock,
  // bench command
  input wire logic pull [2],
  // block side
  input wire hfs_tx_out_t tx_out [2],
  output logic tx_req [2],
  output logic tx_sent_done [2],
  // captured answer
  output hfs_tx_out_t seen [2]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req_d [2];
  // ==========
  // behaviour
  initial begin
    tx_req = '{1'b0, 1'b0};
    tx_sent_done = '{1'b0, 1'b0};
    req_d = '{1'b0, 1'b0};
    seen = '{default: '0};
  end
  always @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      tx_req[i] <= pull[i];
      req_d[i] <= tx_req[i];
      // the answer cycle is captured whole, so a missing byte shows as valid and last low
      if (req_d[i]) begin
        seen[i] <= tx_out[i];
      end
      tx_sent_done[i] <= tx_out[i].valid && tx_out[i].last;
    end
  end
endmodule : hfs_framer_model
`default_nettype wire

// ### verification/hfs_top_test.sv
// self-checking bench for the hdlc fifo/status block
`default_nettype none
module hfs_top_test import hfs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset_n, reg_wr, reg_rd, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  hfs_rx_in_t rx_in [2];
  logic [7:0] rx_high_mark [2], tx_low_mark [2];
  logic tx_req [2], tx_sent_done [2], pull [2];
  hfs_tx_out_t tx_out [2], seen [2];
  int miscompares, n_compared, cyc, c;
  localparam logic [7:0] RA [6] = '{8'h2d, 8'h2e, 8'h2f, 8'h9c, 8'haf, 8'h21};
  localparam logic [7:0] RV [6] = '{8'h00, 8'h28, 8'h28, 8'h00, 8'h80, 8'h00};
  localparam int NB [4] = '{4, 1, 4, 4};
  localparam logic [2:0] PS [4] = '{3'h1, 3'h5, 3'h2, 3'h3};
  hfs_top i_hfs_top (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_in(rx_in), .rx_high_mark(rx_high_mark), .tx_low_mark(tx_low_mark),
    .tx_req(tx_req), .tx_sent_done(tx_sent_done), .tx_out(tx_out), .irq(irq));
  hfs_framer_model i_hfs_framer_model (.clock(clock), .pull(pull), .tx_out(tx_out),
    .tx_req(tx_req), .tx_sent_done(tx_sent_done), .seen(seen));
  // ==========
  // tasks
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
    @(posedge clock);
  endtask : rd
  task automatic rx(input int k, input logic [7:0] d, input logic e, input logic ok);
    rx_in[k] <= {1'b1, d, e, ok, 2'b00};
    @(posedge clock);
    rx_in[k] <= '0;
    @(posedge clock);
  endtask : rx
  task automatic pl(input int k);
    pull[k] <= 1'b1;
    @(posedge clock);
    pull[k] <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : pl
  // irq is registered, so allow the stated cycle plus margin before looking
  task automatic ci(input logic e);
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("irq", {7'h0, irq}, {7'h0, e});
    @(posedge clock);
  endtask : ci
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ==========
  // tests
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    rx_in = '{default: '0};
    rx_high_mark = '{8'h40, 8'h40};
    tx_low_mark = '{8'h10, 8'h10};
    pull = '{1'b0, 1'b0};
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 6; i++) begin
      rd(RA[i], v);
      chk("reset", v, RV[i]);
    end
    $display("test reset done");
    for (int i = 0; i < 3; i++) wr(8'h9d, 8'(8'h11 * (i + 1)));
    rd(8'h9f, v);
    chk("space", v, 8'h7d);
    wr(8'h2a, 8'h01);
    for (int i = 0; i < 4; i++) begin
      pl(0);
      if (i < 3) chk("tx byte", seen[0].data, 8'(8'h11 * (i + 1)));
      chk("tx flags", {5'h0, seen[0].valid, seen[0].last, seen[0].abort},
          {5'h0, i < 3, i == 2, 1'b0});
    end
    rd(8'h20, v);
    chk("msg end", {7'h0, v[6]}, 8'h01);
    wr(8'had, 8'h55);
    pl(1);
    chk("tx byte", seen[1].data, 8'h55);
    pl(1);
    chk("abort", {5'h0, seen[1].valid, seen[1].last, seen[1].abort}, 8'h01);
    rd(8'h2d, v);
    chk("underrun", v, 8'h08);
    rd(8'h2d, v);
    chk("underrun clr", v, 8'h00);
    for (int i = 0; i < 129; i++) wr(8'h9d, 8'(i));
    rd(8'h9f, v);
    chk("space full", v, 8'h00);
    rd(8'h2e, v);
    chk("tx flags", {6'h0, v[5:4]}, 8'h01);
    $display("test transmit done");
    ci(1'b0);
    wr(8'h21, 8'h04);
    rx(0, 8'h5a, 1'b0, 1'b1);
    ci(1'b1);
    rd(8'h20, v);
    chk("not empty", {7'h0, v[2]}, 8'h01);
    ci(1'b0);
    wr(8'h21, 8'h28);
    rx(0, 8'h5b, 1'b1, 1'b1);
    ci(1'b1);
    wr(8'h21, 8'h00);
    ci(1'b0);
    rd(8'h20, v);
    rd(8'h9e, v);
    chk("rx byte", v, 8'h5a);
    rd(8'h9e, v);
    $display("test interrupt done");
    for (int i = 0; i < 4; i++) begin
      c = i % 2;
      for (int j = 0; j < NB[i]; j++) rx(c, 8'(8'ha0 + j), j == NB[i] - 1 && i != 3, i != 2);
      if (i == 3) begin
        rd(8'h9c + 8'(16 * c), v);
        chk("count open", v, 8'h84);
        rx_in[c] <= 13'h0003;
        repeat (7) @(posedge clock);
        rx_in[c] <= '0;
        @(posedge clock);
      end
      rd(8'h9c + 8'(16 * c), v);
      chk("count", v, 8'(NB[i]));
      rd(8'h2d, v);
      chk("opening", {7'h0, v[2 * c]}, 8'h01);
      for (int j = 0; j < NB[i]; j++) begin
        rd(8'h9e + 8'(16 * c), v);
        chk("rx byte", v, 8'(8'ha0 + j));
        rd(8'h2e + 8'(c), v);
        if (j < NB[i] - 1) chk("open", {5'h0, v[2:0]}, 8'h00);
      end
      chk("code", {5'h0, v[2:0]}, {5'h0, PS[i]});
      rd(8'h20 + 8'(2 * c), v);
      chk("events", {6'h0, v[5:4]}, 8'h03);
      rd(8'h20 + 8'(2 * c), v);
      chk("events clr", {6'h0, v[5:4]}, 8'h00);
    end
    $display("test receive done");
    // a full fifo mid-message ends it; 128 readable bytes report as 127 plus continuation
    for (int i = 0; i < 129; i++) rx(0, 8'(i), 1'b0, 1'b1);
    rd(8'h9c, v);
    chk("count cap", v, 8'hff);
    for (int i = 0; i < 128; i++) begin
      rd(8'h9e, v);
      chk("rx fill", v, 8'(i));
    end
    rd(8'h2e, v);
    chk("overrun", {5'h0, v[2:0]}, 8'h04);
    rd(8'h9c, v);
    chk("count empty", v, 8'h00);
    $display("test overrun done");
    print_verdict();
  end
endmodule : hfs_top_test
`default_nettype wire
